// File: hdl/tppc_pkg.sv
// constants and types for the touch probe position capture block
package tppc_pkg;
    // widths
    localparam int unsigned POS_W     = 32;
    localparam int unsigned TIME_W    = 16;
    // clock and timing
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned FILT_MIN_NS    = 100;     // fast input type
    localparam int unsigned FILT_MAX_US    = 500;     // slow input type, 0.5 ms
    localparam int unsigned SAMPLE_US      = 125;
    localparam int unsigned FILT_MIN_CYC   = (FILT_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
    localparam int unsigned FILT_MAX_CYC   = FILT_MAX_US * CLK_MHZ;
    localparam int unsigned SAMPLE_CYC     = SAMPLE_US * CLK_MHZ;
    // reciprocal of the sample period in cycles, scaled by 2^RECIP_SH
    localparam int unsigned RECIP_SH       = 32;
    // rounded 2^RECIP_SH over the sample period
    localparam logic [31:0] SAMPLE_RECIP   = 32'(((64'd1 << RECIP_SH) + 64'(SAMPLE_CYC / 2))
                                             / 64'(SAMPLE_CYC));
    // source select
    localparam logic SRC_QUAD  = 1'b0;
    localparam logic SRC_MOTOR = 1'b1;
    typedef enum logic [1:0]
    {
        TPPC_IDLE = 2'b00,
        TPPC_WAIT = 2'b01,
        TPPC_CALC = 2'b10
    } tppc_state_t;
endpackage

// File: hdl/tppc_top.sv
// touch probe position capture from quadrature counter or serial motor encoder
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - with the quadrature source, the live count is latched the moment the filtered probe fires.
// - the probe input passes a filter whose delay lies between 100 ns and 0.5 ms per input type.
// - with the motor source, a new encoder sample is requested once every 125 us.
// - with the motor source, the time within the current sample period at which the probe fired is recorded.
// - velocity is the newest sample minus the one before, over the period.
// - the captured position is the newest sample plus velocity times the recorded time offset, one period longer when that sample predates the current period.
// - no acceleration term enters the estimate.
// - at constant velocity the estimate lands within one count of the true position.
module tppc_top
    import tppc_pkg::*;
#(
    parameter int unsigned FILT_MAX_CYC_P = tppc_pkg::FILT_MAX_CYC,
    parameter int unsigned SAMPLE_CYC_P   = tppc_pkg::SAMPLE_CYC
)
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // configuration
    input  wire logic                       src_sel,
    input  wire logic                       slow_input,
    input  wire logic                       arm,
    // probe pin
    input  wire logic                       probe_in,
    // quadrature counter
    input  wire logic [tppc_pkg::POS_W-1:0] quad_count,
    // serial encoder sample port
    output logic                            enc_req,
    input  wire logic                       enc_valid,
    input  wire logic [tppc_pkg::POS_W-1:0] enc_pos,
    // result
    output logic                            cap_done,
    output logic [tppc_pkg::POS_W-1:0]      cap_pos,
    output logic [tppc_pkg::TIME_W-1:0]     cap_time
);
    import tppc_pkg::*;

    // reciprocal of the period actually in use, so a shortened period scales right
    localparam logic [31:0] RECIP_P = 32'(((64'd1 << RECIP_SH) + 64'(SAMPLE_CYC_P / 2))
                                      / 64'(SAMPLE_CYC_P));

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    typedef struct packed
    {
        logic [2:0]        sync;
        logic              filt;
        logic [19:0]       fcnt;
        logic [15:0]       tcnt;
        logic              enc_req;
        logic [POS_W-1:0]  p0;
        logic [POS_W-1:0]  p1;
        logic [POS_W-1:0]  p2;
        logic              motor_pend;
        logic              fresh;
        logic              stale;
        logic [TIME_W-1:0] t_evt;
        tppc_state_t       st;
        logic              done;
        logic [POS_W-1:0]  pos;
        logic [TIME_W-1:0] time_o;
    } tppc_reg_t;

    tppc_reg_t s_q;
    tppc_reg_t s_d;

    // signed product of velocity and elapsed time, scaled back to counts
    function automatic logic [POS_W-1:0] tppc_extrap(input logic [POS_W-1:0] base,
                                                     input logic [POS_W-1:0] v1,
                                                     input logic [POS_W-1:0] v2,
                                                     input logic [TIME_W-1:0] t);
        logic signed [POS_W-1:0]  dv;
        logic signed [95:0]       prod;
        dv   = $signed(v1 - v2);
        prod = 96'(dv) * $signed({1'b0, t}) * $signed({1'b0, RECIP_P});
        prod = prod + (96'sd1 <<< (RECIP_SH - 1));
        return base + prod[RECIP_SH +: POS_W];
    endfunction

    logic [19:0]       filt_lim;
    logic              rise;
    logic [TIME_W-1:0] t_off;

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    always_comb
    begin
        s_d      = s_q;
        filt_lim = slow_input ? 20'(FILT_MAX_CYC_P) : 20'(FILT_MIN_CYC);
        rise     = 1'b0;
        // offset from the newest sample; a period more if it predates this period
        t_off    = s_q.stale ? s_q.t_evt + 16'(SAMPLE_CYC_P) : s_q.t_evt;
        s_d.done = 1'b0;
        s_d.sync = {s_q.sync[1:0], probe_in};
        // filter: change counts once stages two and three agree for the delay
        if (s_q.sync[2] != s_q.sync[1] || s_q.sync[2] == s_q.filt)
        begin
            s_d.fcnt = 20'h00000;
        end
        else if (s_q.fcnt + 20'h00001 >= filt_lim)
        begin
            s_d.filt = s_q.sync[2];
            s_d.fcnt = 20'h00000;
            rise     = s_q.sync[2];
        end
        else
        begin
            s_d.fcnt = s_q.fcnt + 20'h00001;
        end
        // sample period timer and request
        s_d.enc_req = 1'b0;
        if (s_q.tcnt == 16'(SAMPLE_CYC_P - 1))
        begin
            s_d.tcnt    = 16'h0000;
            s_d.enc_req = 1'b1;
        end
        else
        begin
            s_d.tcnt = s_q.tcnt + 16'h0001;
        end
        // sample history, newest first
        if (enc_valid)
        begin
            s_d.p2 = s_q.p1;
            s_d.p1 = s_q.p0;
            s_d.p0 = enc_pos;
        end
        // a sample has landed since the current period began; arrival wins
        if (s_d.enc_req)
        begin
            s_d.fresh = 1'b0;
        end
        if (enc_valid)
        begin
            s_d.fresh = 1'b1;
        end
        case (s_q.st)
            TPPC_IDLE:
            begin
                if (arm)
                begin
                    s_d.st = TPPC_WAIT;
                end
            end
            TPPC_WAIT:
            begin
                if (rise && src_sel == SRC_QUAD)
                begin
                    s_d.pos    = quad_count;
                    s_d.time_o = 16'h0000;
                    s_d.done   = 1'b1;
                    s_d.st     = TPPC_IDLE;
                end
                else if (rise)
                begin
                    s_d.t_evt = s_q.tcnt;
                    s_d.stale = !(s_q.fresh || enc_valid);
                    s_d.st    = TPPC_CALC;
                end
            end
            TPPC_CALC:
            begin
                // estimate from newest sample and the one before; no acceleration term
                s_d.pos    = tppc_extrap(s_q.p0, s_q.p0, s_q.p1, t_off);
                s_d.time_o = s_q.t_evt;
                s_d.done   = 1'b1;
                s_d.st     = TPPC_IDLE;
            end
            default:
            begin
                s_d.st = TPPC_IDLE;
            end
        endcase
    end

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign enc_req  = s_q.enc_req;
    assign cap_done = s_q.done;
    assign cap_pos  = s_q.pos;
    assign cap_time = s_q.time_o;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    property p_quad_latch;
        @(posedge clk) disable iff (rst)
        (s_q.st == TPPC_WAIT && rise && src_sel == SRC_QUAD) |=> cap_done && cap_pos == $past(quad_count);
    endproperty
    a_quad_latch: assert property (p_quad_latch) else $error("quad count not latched");

    property p_filt_hold;
        @(posedge clk) disable iff (rst)
        $changed(s_q.filt) |-> $past(s_q.sync[2]) == s_q.filt;
    endproperty
    a_filt_hold: assert property (p_filt_hold) else $error("filter changed without input");

    property p_req_period;
        @(posedge clk) disable iff (rst)
        enc_req |=> !enc_req [*2];
    endproperty
    a_req_period: assert property (p_req_period) else $error("sample request too frequent");

    property p_time_rec;
        @(posedge clk) disable iff (rst)
        (s_q.st == TPPC_WAIT && rise && src_sel == SRC_MOTOR) |=> s_q.t_evt == $past(s_q.tcnt);
    endproperty
    a_time_rec: assert property (p_time_rec) else $error("event time not recorded");

    property p_motor_done;
        @(posedge clk) disable iff (rst)
        (s_q.st == TPPC_WAIT && rise && src_sel == SRC_MOTOR) |=> ##1 cap_done;
    endproperty
    a_motor_done: assert property (p_motor_done) else $error("motor capture late");

    property p_zero_time;
        @(posedge clk) disable iff (rst)
        (s_q.st == TPPC_CALC && t_off == 16'h0000) |=> cap_pos == $past(s_q.p0);
    endproperty
    a_zero_time: assert property (p_zero_time) else $error("zero offset changed position");

    property p_still;
        @(posedge clk) disable iff (rst)
        (s_q.st == TPPC_CALC && s_q.p0 == s_q.p1) |=> cap_pos == $past(s_q.p0);
    endproperty
    a_still: assert property (p_still) else $error("nonzero move at zero velocity");

    property p_done_pulse;
        @(posedge clk) disable iff (rst)
        cap_done |=> !cap_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
endmodule
`default_nettype wire

// File: sim/tppc_enc_model.sv
// serial motor encoder model answering sample requests
`timescale 1ns/1ps
`default_nettype none
module tppc_enc_model
#(
    parameter int unsigned LAT = 2
)
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // sample port
    input  wire logic                       enc_req,
    input  wire logic [tppc_pkg::POS_W-1:0] true_pos,
    output logic                            enc_valid,
    output logic [tppc_pkg::POS_W-1:0]      enc_pos
);
    import tppc_pkg::*;
    logic [POS_W-1:0] snap;
    int               wait_n;
    // snapshot at request, answer after a lag, scrambled data when idle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_n    <= 0;
            enc_valid <= 1'b0;
            enc_pos   <= '0;
        end
        else
        begin
            enc_valid <= 1'b0;
            enc_pos   <= ~enc_pos;
            if (enc_req)
            begin
                snap   <= true_pos;
                wait_n <= LAT;
            end
            else if (wait_n == 1)
            begin
                enc_valid <= 1'b1;
                enc_pos   <= snap;
                wait_n    <= 0;
            end
            else if (wait_n > 1)
                wait_n <= wait_n - 1;
        end
    end
endmodule
`default_nettype wire

// File: sim/tppc_top_bench.sv
// self-checking bench for the touch probe position capture block
`timescale 1ns/1ps
`default_nettype none
module tppc_top_bench;
    import tppc_pkg::*;
    localparam int FMAX = 50;
    logic              clk = 1'b0, rst = 1'b1, src_sel = 1'b0, slow_input = 1'b0;
    logic              arm = 1'b0, probe_in = 1'b0, enc_req, enc_valid, cap_done;
    logic [POS_W-1:0]  quad_count = '0, enc_pos, cap_pos, exp_v;
    logic [TIME_W-1:0] cap_time;
    int                failures = 0, samples_checked = 0, seed = 65551, gap = 0;
    logic [POS_W-1:0]  exp_q[$];
    logic [TIME_W-1:0] exp_t, exp_t_q[$];
    // clock and a position ramp of one count per cycle
    always #2.5 clk = ~clk;
    always @(posedge clk) quad_count <= quad_count + 1;
    tppc_top #(.FILT_MAX_CYC_P(FMAX), .SAMPLE_CYC_P(SAMPLE_CYC)) dut (.clk(clk), .rst(rst),
        .src_sel(src_sel), .slow_input(slow_input), .arm(arm), .probe_in(probe_in),
        .quad_count(quad_count), .enc_req(enc_req), .enc_valid(enc_valid),
        .enc_pos(enc_pos), .cap_done(cap_done), .cap_pos(cap_pos), .cap_time(cap_time));
    tppc_enc_model #(.LAT(2)) enc (.clk(clk), .rst(rst), .enc_req(enc_req),
        .true_pos(quad_count), .enc_valid(enc_valid), .enc_pos(enc_pos));
    // verdict and end of run
    task automatic end_sim();
        if (exp_q.size() != 0)
            failures++;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // arm, raise the probe at a random moment, note the position expected
    task automatic capture(input logic src, input logic slow, input int lag);
        int n;
        @(posedge clk);
        src_sel    <= src;
        slow_input <= slow;
        arm        <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
        repeat (2 + ($unsigned($random(seed)) % 8)) @(posedge clk);
        probe_in <= 1'b1;
        exp_q.push_back(quad_count + 3 + lag);
        exp_t_q.push_back((src == SRC_QUAD) ? 16'h0000 : 16'((gap + 3 + lag) % SAMPLE_CYC));
        n = 0;
        while (cap_done !== 1'b1 && n < lag + 40)
        begin
            @(posedge clk);
            n++;
        end
        probe_in <= 1'b0;
        repeat (lag + 8) @(posedge clk);
    endtask
    // probe pulse that must not lead to a capture
    task automatic pulse(input int len);
        probe_in <= 1'b1;
        repeat (len) @(posedge clk);
        probe_in <= 1'b0;
        repeat (FMAX + 10) @(posedge clk);
    endtask
    // result watcher: oldest note against each capture, within tolerance
    always @(posedge clk)
    begin
        if (cap_done === 1'b1)
        begin
            samples_checked++;
            exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : ~cap_pos;
            exp_t = (exp_t_q.size() != 0) ? exp_t_q.pop_front() : ~cap_time;
            if (((cap_pos - exp_v + 32'h1) <= 32'h2) !== 1'b1)
            begin
                failures++;
                $display("ERROR %0t got %h exp %h", $time, cap_pos, exp_v);
            end
            if (cap_time !== exp_t)
            begin
                failures++;
                $display("ERROR %0t time %h exp %h", $time, cap_time, exp_t);
            end
        end
    end
    // sample request spacing
    always @(posedge clk)
    begin
        gap <= rst ? 0 : gap + 1;
        if (enc_req === 1'b1)
        begin
            gap <= 1;
            if (gap != 0 && gap != SAMPLE_CYC)
            begin
                failures++;
                $display("ERROR %0t gap %h exp %h", $time, gap, SAMPLE_CYC);
            end
        end
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        capture(SRC_QUAD, 1'b0, FILT_MIN_CYC);
        pulse(30);
        slow_input <= 1'b1;
        arm        <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
        pulse(FMAX - 10);
        capture(SRC_QUAD, 1'b1, FMAX);
        repeat (2 * SAMPLE_CYC) @(posedge clk);
        capture(SRC_MOTOR, 1'b0, FILT_MIN_CYC);
        end_sim();
    end
    // watchdog
    initial
    begin
        repeat (90000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule
`default_nettype wire
